// >>> rtl/qpm_mapper.sv
// Operation
// - table a: prio fields dscp 32..47
// - table b: prio fields dscp 48..63
// - dscp field gives priority, indexes queue table
// - dscp priority fields reset to zero
// - queue table: two bits per priority
// - queue fields reset to zero
// - mirroring uses cos bits 2:0
// - address learning uses cos bits 5:3
// - normal switching uses cos bits 8:6
// - protocol termination uses cos bits 11:9
// - protocol snooping uses cos bits 14:12
// - exception or flooding uses bits 17:15
// - several reasons: largest class wins
// - bits 31:18 read-only zero; fields reset zero
`timescale 1ns/1ps
`default_nettype none
module qpm_mapper (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // paged byte register port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_page_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  // dscp lookup
  input  wire logic       dscp_req_i,
  input  wire logic [5:0] dscp_i,
  output logic            dscp_valid_o,
  output logic            dscp_hit_o,
  output logic      [2:0] dscp_prio_o,
  output logic      [1:0] dscp_queue_o,
  // cpu class lookup
  input  wire logic       cpu_req_i,
  input  wire logic [5:0] cpu_reason_i,
  output logic            cpu_valid_o,
  output logic      [2:0] cpu_cos_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [47:0] map_a;
    logic [47:0] map_b;
    logic [15:0] pq;
    logic [17:0] cpu;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        lk_valid;
    logic        lk_hit;
    logic [2:0]  lk_prio;
    logic [1:0]  lk_queue;
    logic        cos_valid;
    logic [2:0]  cos;
  } qpm_state_t;

  qpm_state_t st_reg;
  qpm_state_t st_next;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // three-bit field number idx of a 48-bit table
  function automatic logic [2:0] fld3(input logic [47:0] tbl, input logic [3:0] idx);
    fld3 = tbl[idx*3 +: 3];
  endfunction : fld3

  // two-bit queue field for a priority
  function automatic logic [1:0] qfld(input logic [15:0] tbl, input logic [2:0] prio);
    qfld = tbl[prio*2 +: 2];
  endfunction : qfld

  // largest class among the flagged reasons, zero when none
  function automatic logic [2:0] max_cos(input logic [17:0] tbl, input logic [5:0] rsn);
    logic [2:0] m;
    m = 3'h0;
    for (int k = 0; k < qpm_pkg::QPM_REASONS; k++) begin
      if (rsn[k] && tbl[k*3 +: 3] > m) begin
        m = tbl[k*3 +: 3];
      end
    end
    max_cos = m;
  endfunction : max_cos

  // byte read view of the page; unmapped and reserved bytes read zero
  function automatic logic [7:0] rd_byte(input qpm_state_t s, input logic [7:0] a);
    logic [31:0] cpu_w;
    logic [7:0]  d;
    cpu_w = {14'h0000, s.cpu};
    d     = 8'h00;
    for (int k = 0; k < qpm_pkg::QPM_MAP_BYTES; k++) begin
      if (a == qpm_pkg::QPM_MAP_A_OFS + 8'(k)) begin
        d = s.map_a[k*8 +: 8];
      end
      if (a == qpm_pkg::QPM_MAP_B_OFS + 8'(k)) begin
        d = s.map_b[k*8 +: 8];
      end
    end
    for (int k = 0; k < qpm_pkg::QPM_PQ_BYTES; k++) begin
      if (a == qpm_pkg::QPM_PQ_OFS + 8'(k)) begin
        d = s.pq[k*8 +: 8];
      end
    end
    for (int k = 0; k < qpm_pkg::QPM_CPU_BYTES; k++) begin
      if (a == qpm_pkg::QPM_CPU_OFS + 8'(k)) begin
        d = cpu_w[k*8 +: 8];
      end
    end
    rd_byte = d;
  endfunction : rd_byte

  // ****************************************************************
  // next state
  // ****************************************************************
  logic       pg_hit;
  logic [2:0] prio_c;
  logic       hit_c;
  logic [31:0] cpu_wr;

  always_comb begin
    st_next = st_reg;
    pg_hit  = (reg_page_i == qpm_pkg::QPM_PAGE);
    cpu_wr  = {14'h0000, st_reg.cpu};
    // byte writes into the tables
    if (reg_wr_i && pg_hit) begin
      for (int k = 0; k < qpm_pkg::QPM_MAP_BYTES; k++) begin
        if (reg_addr_i == qpm_pkg::QPM_MAP_A_OFS + 8'(k)) begin
          st_next.map_a[k*8 +: 8] = reg_wdata_i;
        end
        if (reg_addr_i == qpm_pkg::QPM_MAP_B_OFS + 8'(k)) begin
          st_next.map_b[k*8 +: 8] = reg_wdata_i;
        end
      end
      for (int k = 0; k < qpm_pkg::QPM_PQ_BYTES; k++) begin
        if (reg_addr_i == qpm_pkg::QPM_PQ_OFS + 8'(k)) begin
          st_next.pq[k*8 +: 8] = reg_wdata_i;
        end
      end
      for (int k = 0; k < qpm_pkg::QPM_CPU_BYTES; k++) begin
        if (reg_addr_i == qpm_pkg::QPM_CPU_OFS + 8'(k)) begin
          cpu_wr[k*8 +: 8] = reg_wdata_i;
        end
      end
      st_next.cpu = cpu_wr[17:0];
    end
    // read answer one cycle after the strobe
    st_next.rd_valid = reg_rd_i;
    st_next.rd_data  = (reg_rd_i && pg_hit) ? rd_byte(st_reg, reg_addr_i) : 8'h00;
    // dscp lookup against the current tables
    case (dscp_i[5:4])
      qpm_pkg::QPM_DSCP_SEL_A: begin
        hit_c  = 1'b1;
        prio_c = fld3(st_reg.map_a, dscp_i[3:0]);
      end
      qpm_pkg::QPM_DSCP_SEL_B: begin
        hit_c  = 1'b1;
        prio_c = fld3(st_reg.map_b, dscp_i[3:0]);
      end
      default: begin
        hit_c  = 1'b0;
        prio_c = 3'h0;
      end
    endcase
    st_next.lk_valid = dscp_req_i;
    if (dscp_req_i) begin
      st_next.lk_hit   = hit_c;
      st_next.lk_prio  = prio_c;
      st_next.lk_queue = qfld(st_reg.pq, prio_c);
    end
    // cpu class of service
    st_next.cos_valid = cpu_req_i;
    if (cpu_req_i) begin
      st_next.cos = max_cos(st_reg.cpu, cpu_reason_i);
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg       <= '0;
      st_reg.map_a <= qpm_pkg::QPM_MAP_RST;
      st_reg.map_b <= qpm_pkg::QPM_MAP_RST;
      st_reg.pq    <= qpm_pkg::QPM_PQ_RST;
      st_reg.cpu   <= qpm_pkg::QPM_CPU_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o  = st_reg.rd_data;
  assign reg_rvalid_o = st_reg.rd_valid;
  assign dscp_valid_o = st_reg.lk_valid;
  assign dscp_hit_o   = st_reg.lk_hit;
  assign dscp_prio_o  = st_reg.lk_prio;
  assign dscp_queue_o = st_reg.lk_queue;
  assign cpu_valid_o  = st_reg.cos_valid;
  assign cpu_cos_o    = st_reg.cos;

  // ****************************************************************
  // checks
  // ****************************************************************
  tables_reset_a : assert property (
    @(posedge clk_i) $rose(arst_n_i) |->
      st_reg.map_a == qpm_pkg::QPM_MAP_RST && st_reg.map_b == qpm_pkg::QPM_MAP_RST &&
      st_reg.pq == qpm_pkg::QPM_PQ_RST && st_reg.cpu == qpm_pkg::QPM_CPU_RST)
    else $error("tables not zero after reset");

  map_a_low_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      reg_wr_i && reg_page_i == qpm_pkg::QPM_PAGE &&
      reg_addr_i == qpm_pkg::QPM_MAP_A_OFS |=>
        st_reg.map_a[7:0] == $past(reg_wdata_i))
    else $error("table a low byte not written");

  map_b_top_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      reg_wr_i && reg_page_i == qpm_pkg::QPM_PAGE &&
      reg_addr_i == qpm_pkg::QPM_MAP_B_OFS + 8'h05 |=>
        st_reg.map_b[47:40] == $past(reg_wdata_i))
    else $error("table b top byte not written");

  dscp_prio_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      dscp_req_i && dscp_i == 6'h35 |=> dscp_valid_o && dscp_hit_o && dscp_prio_o == $past(st_reg.map_b[17:15]))
    else $error("dscp 53 priority wrong");

  dscp_queue_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      dscp_valid_o |-> dscp_queue_o == st_reg.pq[dscp_prio_o*2 +: 2] || $past(reg_wr_i))
    else $error("queue does not follow priority");

  dscp_low_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      dscp_req_i && !dscp_i[5] |=> !dscp_hit_o && dscp_prio_o == 3'h0)
    else $error("lower dscp half reported as hit");

  cos_single_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      cpu_req_i && cpu_reason_i == 6'h20 |=> cpu_valid_o && cpu_cos_o == $past(st_reg.cpu[17:15]))
    else $error("exception class wrong");

  cos_max_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      cpu_req_i && cpu_reason_i[1] && cpu_reason_i[2] |=>
        cpu_cos_o >= $past(st_reg.cpu[5:3]) && cpu_cos_o >= $past(st_reg.cpu[8:6]))
    else $error("class below a flagged reason");

  cpu_rsvd_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      reg_rd_i && reg_page_i == qpm_pkg::QPM_PAGE &&
      reg_addr_i == qpm_pkg::QPM_CPU_OFS + 8'h03 |=>
        reg_rvalid_o && reg_rdata_o == 8'h00)
    else $error("reserved class byte not zero");

  queue_hi_write_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      reg_wr_i && reg_page_i == qpm_pkg::QPM_PAGE &&
      reg_addr_i == qpm_pkg::QPM_PQ_OFS + 8'h01 |=>
        st_reg.pq[15:8] == $past(reg_wdata_i))
    else $error("queue table top byte not written");

  cpu_hi_write_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      reg_wr_i && reg_page_i == qpm_pkg::QPM_PAGE &&
      reg_addr_i == qpm_pkg::QPM_CPU_OFS + 8'h02 |=>
        st_reg.cpu[17:16] == $past(reg_wdata_i[1:0]))
    else $error("class table top field not written");

  cos_mirror_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      cpu_req_i && cpu_reason_i == 6'h01 |=> cpu_valid_o && cpu_cos_o == $past(st_reg.cpu[2:0]))
    else $error("mirror class wrong");

  cos_learn_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      cpu_req_i && cpu_reason_i == 6'h02 |=> cpu_valid_o && cpu_cos_o == $past(st_reg.cpu[5:3]))
    else $error("learning class wrong");

  cos_switch_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      cpu_req_i && cpu_reason_i == 6'h04 |=> cpu_valid_o && cpu_cos_o == $past(st_reg.cpu[8:6]))
    else $error("switching class wrong");

  cos_term_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      cpu_req_i && cpu_reason_i == 6'h08 |=> cpu_valid_o && cpu_cos_o == $past(st_reg.cpu[11:9]))
    else $error("termination class wrong");

  cos_snoop_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      cpu_req_i && cpu_reason_i == 6'h10 |=> cpu_valid_o && cpu_cos_o == $past(st_reg.cpu[14:12]))
    else $error("snooping class wrong");

  cos_none_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      cpu_req_i && cpu_reason_i == 6'h00 |=> cpu_valid_o && cpu_cos_o == 3'h0)
    else $error("class not zero without reasons");

  dscp_a_top_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      dscp_req_i && dscp_i == 6'h2F |=> dscp_hit_o && dscp_prio_o == $past(st_reg.map_a[47:45]))
    else $error("dscp 47 priority wrong");

  dscp_b_top_a : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
      dscp_req_i && dscp_i == 6'h3F |=> dscp_hit_o && dscp_prio_o == $past(st_reg.map_b[47:45]))
    else $error("dscp 63 priority wrong");

endmodule : qpm_mapper
`default_nettype wire

// >>> pkg/qpm_pkg.sv
`default_nettype none
// ****************************************************************
// qos mapper constants
// ****************************************************************
package qpm_pkg;
  // register page holding all tables
  localparam logic [7:0]  QPM_PAGE          = 8'h30;
  // byte offsets within the page
  localparam logic [7:0]  QPM_MAP_A_OFS     = 8'h3C;
  localparam logic [7:0]  QPM_MAP_B_OFS     = 8'h42;
  localparam logic [7:0]  QPM_PQ_OFS        = 8'h62;
  localparam logic [7:0]  QPM_CPU_OFS       = 8'h64;
  // sizes in bytes
  localparam int          QPM_MAP_BYTES     = 6;
  localparam int          QPM_PQ_BYTES      = 2;
  localparam int          QPM_CPU_BYTES     = 4;
  // field widths and positions
  localparam int          QPM_PRIO_W        = 3;
  localparam int          QPM_QUEUE_W       = 2;
  localparam int          QPM_COS_W         = 3;
  localparam int          QPM_REASONS       = 6;
  localparam int          QPM_CPU_USED_W    = 18;
  // reason vector positions
  localparam int          QPM_RSN_MIRROR    = 0;
  localparam int          QPM_RSN_LEARN     = 1;
  localparam int          QPM_RSN_SWITCH    = 2;
  localparam int          QPM_RSN_TERM      = 3;
  localparam int          QPM_RSN_SNOOP     = 4;
  localparam int          QPM_RSN_EXCEPT    = 5;
  // values after reset
  localparam logic [47:0] QPM_MAP_RST       = 48'h0000_0000_0000;
  localparam logic [15:0] QPM_PQ_RST        = 16'h0000;
  localparam logic [17:0] QPM_CPU_RST       = 18'h00000;
  // dscp upper bits selecting each table
  localparam logic [1:0]  QPM_DSCP_SEL_A    = 2'h2;
  localparam logic [1:0]  QPM_DSCP_SEL_B    = 2'h3;
endpackage : qpm_pkg
`default_nettype wire

// >>> tb/test_qpm_mapper.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// qos mapper bench
// ****************************************************************
module test_qpm_mapper;
  logic        clk_i, arst_n_i, reg_wr_i, reg_rd_i, dscp_req_i, cpu_req_i;
  logic [7:0]  reg_page_i, reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic        reg_rvalid_o, dscp_valid_o, dscp_hit_o, cpu_valid_o;
  logic [5:0]  dscp_i, cpu_reason_i;
  logic [2:0]  dscp_prio_o, cpu_cos_o, pe, me;
  logic [1:0]  dscp_queue_o;
  int          mismatches, check_count, cycles;
  localparam logic [47:0] MAP_A = 48'hFAC6_88E3_9705;
  localparam logic [47:0] MAP_B = 48'h1234_5678_9ABC;
  localparam logic [15:0] PQ    = 16'hE4B1;
  localparam logic [17:0] COS   = 18'h29C53;

  qpm_mapper dut (.clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i, .reg_page_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .dscp_req_i, .dscp_i, .dscp_valid_o,
    .dscp_hit_o, .dscp_prio_o, .dscp_queue_o, .cpu_req_i, .cpu_reason_i, .cpu_valid_o,
    .cpu_cos_o);

  // 125 mhz clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] pg, logic [7:0] a, logic [7:0] d);
    reg_wr_i <= 1'b1; reg_page_i <= pg; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(logic [7:0] pg, logic [7:0] a, logic [7:0] exp);
    reg_rd_i <= 1'b1; reg_page_i <= pg; reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid_o});
    chk("rdata", exp, reg_rdata_o);
    @(posedge clk_i);
  endtask : rd
  task automatic look(logic [5:0] c, logic [2:0] p, logic [1:0] q);
    dscp_req_i <= 1'b1; dscp_i <= c;
    @(posedge clk_i);
    dscp_req_i <= 1'b0;
    #1;
    chk("dscp_valid", 8'h01, {7'h00, dscp_valid_o});
    chk("dscp_hit", {7'h00, c[5]}, {7'h00, dscp_hit_o});
    chk("dscp_prio", {5'h00, p}, {5'h00, dscp_prio_o});
    chk("dscp_queue", {6'h00, q}, {6'h00, dscp_queue_o});
    @(posedge clk_i);
  endtask : look
  task automatic test_done();
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // expected byte from the written table images
  function automatic logic [7:0] exp_byte(int a);
    if (a >= 8'h3C && a <= 8'h41) return MAP_A[8*(a-8'h3C)+:8];
    if (a >= 8'h42 && a <= 8'h47) return MAP_B[8*(a-8'h42)+:8];
    if (a >= 8'h62 && a <= 8'h63) return PQ[8*(a-8'h62)+:8];
    if (a >= 8'h64 && a <= 8'h65) return COS[8*(a-8'h64)+:8];
    if (a == 8'h66) return {6'h00, COS[17:16]};
    return 8'h00;
  endfunction : exp_byte

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {arst_n_i, reg_wr_i, reg_rd_i, dscp_req_i, cpu_req_i} <= '0;
    {reg_page_i, reg_addr_i, reg_wdata_i, dscp_i, cpu_reason_i} <= '0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    // every byte from 3C to 67 of the page reads zero after reset
    for (int a = 8'h3C; a <= 8'h67; a++) rd(8'h30, 8'(a), 8'h00);
    look(6'h28, 3'h0, 2'h0);
    // load all tables, reserved bits written as ones
    for (int i = 0; i < 6; i++) begin
      wr(8'h30, 8'(8'h3C + i), MAP_A[8*i+:8]);
      wr(8'h30, 8'(8'h42 + i), MAP_B[8*i+:8]);
    end
    wr(8'h30, 8'h62, PQ[7:0]);
    wr(8'h30, 8'h63, PQ[15:8]);
    wr(8'h30, 8'h64, COS[7:0]);
    wr(8'h30, 8'h65, COS[15:8]);
    wr(8'h30, 8'h66, 8'hFE);
    wr(8'h30, 8'h67, 8'hFF);
    wr(8'h31, 8'h3C, 8'hFF);
    for (int a = 8'h3C; a <= 8'h67; a++) rd(8'h30, 8'(a), exp_byte(a));
    rd(8'h31, 8'h3C, 8'h00);
    // every code through the priority and queue tables
    for (int c = 0; c < 64; c++) begin
      pe = (c < 32) ? 3'h0 : (c < 48) ? MAP_A[3*(c-32)+:3] : MAP_B[3*(c-48)+:3];
      look(6'(c), pe, PQ[2*pe+:2]);
    end
    // every combination of cpu reasons
    for (int r = 0; r < 64; r++) begin
      me = 3'h0;
      for (int k = 0; k < 6; k++) if (r[k] && COS[3*k+:3] > me) me = COS[3*k+:3];
      cpu_req_i <= 1'b1;
      cpu_reason_i <= 6'(r);
      @(posedge clk_i);
      cpu_req_i <= 1'b0;
      #1;
      chk("cpu_valid", 8'h01, {7'h00, cpu_valid_o});
      chk("cpu_cos", {5'h00, me}, {5'h00, cpu_cos_o});
      @(posedge clk_i);
    end
    // a second reset in mid-run clears every table again
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int a = 8'h3C; a <= 8'h67; a++) rd(8'h30, 8'(a), 8'h00);
    look(6'h3F, 3'h0, 2'h0);
    test_done();
  end
endmodule : test_qpm_mapper
`default_nettype wire
